// File: rtl/adc_cfg_defs.svh
// register offsets, field positions and reset values of the configuration bank
`ifndef ADC_CFG_DEFS_SVH
`define ADC_CFG_DEFS_SVH
// ==========================================================
// offsets
`define OFS_DIFF_SKEW 8'h70
`define OFS_EDGE_SLIP 8'h71
`define OFS_CLK_RATIO 8'h72
`define OFS_DRV_FMT 8'h73
`define OFS_LOOP_RANGE 8'h74
`define OFS_LC_HI_U0 8'ha4
`define OFS_LC_LO_U0 8'ha5
`define OFS_LS_HI_U0 8'ha6
`define OFS_LS_LO_U0 8'ha7
`define OFS_LC_HI_U1 8'ha8
`define OFS_LC_LO_U1 8'ha9
`define OFS_LS_HI_U1 8'haa
`define OFS_LS_LO_U1 8'hab
`define OFS_CAL_STATE 8'hb6
// ==========================================================
// reset values
`define RST_DIFF_SKEW 8'h80
`define RST_ZERO 8'h00
// ==========================================================
// field positions and codes
`define SLIP_BIT 0
`define RATIO_MSB 2
`define DRV_MSB 7
`define DRV_LSB 5
`define FMT_MSB 2
`define RANGE_BIT 6
`define CAL_DONE_BIT 0
`define RATIO_PIN 3'h0
`define RATIO_DIV1 3'h1
`define RATIO_DIV2 3'h2
`define DRV_DIFF_3MA 3'h0
`define DRV_DIFF_LOW 3'h1
`define DRV_SINGLE 3'h4
`define FMT_TWOS 3'h0
`define FMT_GRAY 3'h2
`define FMT_OFFSET 3'h4
`endif

// File: rtl/adc_cfg_pkg.sv
// types shared by the configuration bank
package adc_cfg_pkg;
    typedef enum logic [1:0] {RATIO_BY_PIN, RATIO_BY_ONE, RATIO_BY_TWO} ratio_mode_e;
    typedef enum logic [1:0] {DRIVE_DIFF_FULL, DRIVE_DIFF_LOW, DRIVE_SINGLE_ENDED} drive_mode_e;
    typedef enum logic [1:0] {FORMAT_TWOS, FORMAT_GRAY, FORMAT_OFFSET} number_format_e;
endpackage : adc_cfg_pkg

// File: rtl/adc_config_output_register_bank.sv
// byte-wide configuration and status registers for clocking, output drive and loop control
`include "adc_cfg_defs.svh"
module adc_config_output_register_bank
    import adc_cfg_pkg::*;
(
    input wire logic sys_clk, // 50 MHz clock
    input wire logic arst_n, // asynchronous power-up reset
    input wire logic soft_rst, // one-cycle soft reset command
    input wire logic wr_en, // one-cycle write strobe
    input wire logic rd_en, // one-cycle read strobe
    input wire logic [7:0] addr, // register address
    input wire logic [7:0] wr_data, // write byte
    input wire logic cal_done_in, // calibration done from core, same clock
    input wire logic [7:0] ls_hi_u0_in, // loop status high, unit 0
    input wire logic [7:0] ls_lo_u0_in, // loop status low, unit 0
    input wire logic [7:0] ls_hi_u1_in, // loop status high, unit 1
    input wire logic [7:0] ls_lo_u1_in, // loop status low, unit 1
    input wire logic ratio_pin, // external divide select pin
    output logic [7:0] rd_data, // read byte
    output logic rd_valid, // read answer pulse
    output logic [7:0] diff_skew, // differential skew value
    output logic edge_slip, // move sampling to next edge
    output logic ratio_pin_ctl, // divider follows the pin
    output logic div_by_two, // conversion clock divided by two
    output logic [1:0] drive_mode, // drive_mode_e value
    output logic [1:0] num_format, // number_format_e value
    output logic loop_slow, // slow loop range selected
    output logic [7:0] lc_hi_u0, // loop control high, unit 0
    output logic [7:0] lc_lo_u0, // loop control low, unit 0
    output logic [7:0] lc_hi_u1, // loop control high, unit 1
    output logic [7:0] lc_lo_u1 // loop control low, unit 1
);

    // ==========================================================
    // storage
    logic [7:0] skew_r;
    logic slip_r;
    // only defined fields are stored, so reserved bits cannot read back
    logic [2:0] ratio_r;
    logic [2:0] drv_r;
    logic [2:0] fmt_r;
    logic range_r;
    logic [7:0] lc_r [4];
    logic pin_s1_r;
    logic pin_s2_r;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    // ==========================================================
    // soft-reset volatile registers
    // a write that meets soft_rst loses; the reset value wins
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            skew_r <= `RST_DIFF_SKEW;
            slip_r <= 1'b0;
        end else if (soft_rst) begin
            skew_r <= `RST_DIFF_SKEW;
            slip_r <= 1'b0;
        end else if (wr_en) begin
            if (hit(addr, `OFS_DIFF_SKEW)) begin
                skew_r <= wr_data;
            end
            if (hit(addr, `OFS_EDGE_SLIP)) begin
                slip_r <= wr_data[`SLIP_BIT];
            end
        end
    end

    // ==========================================================
    // registers kept across soft reset; only power-up clears them
    // soft_rst is left out on purpose so a soft reset cannot glitch the clocking
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ratio_r <= 3'h0;
            drv_r <= 3'h0;
            fmt_r <= 3'h0;
            range_r <= 1'b0;
        end else if (wr_en) begin
            if (hit(addr, `OFS_CLK_RATIO)) begin
                ratio_r <= wr_data[`RATIO_MSB:0];
            end
            if (hit(addr, `OFS_DRV_FMT)) begin
                drv_r <= wr_data[`DRV_MSB:`DRV_LSB];
                fmt_r <= wr_data[`FMT_MSB:0];
            end
            if (hit(addr, `OFS_LOOP_RANGE)) begin
                range_r <= wr_data[`RANGE_BIT];
            end
        end
    end

    // ==========================================================
    // loop control bytes, factory values loaded as zero here
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_lc
            localparam logic [7:0] OFS = (gi == 0) ? `OFS_LC_HI_U0 : (gi == 1) ? `OFS_LC_LO_U0 :
                                         (gi == 2) ? `OFS_LC_HI_U1 : `OFS_LC_LO_U1;
            always_ff @(posedge sys_clk or negedge arst_n) begin
                if (!arst_n) begin
                    lc_r[gi] <= `RST_ZERO;
                end else if (wr_en && hit(addr, OFS)) begin
                    lc_r[gi] <= wr_data;
                end
            end
        end
    endgenerate

    // ==========================================================
    // pin sync; the divide select pin is asynchronous to sys_clk
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            pin_s1_r <= 1'b0;
            pin_s2_r <= 1'b0;
        end else begin
            pin_s1_r <= ratio_pin;
            pin_s2_r <= pin_s1_r;
        end
    end

    // ==========================================================
    // decoded controls; reserved drive and format codes fall back to the reset default, reserved ratio codes to divide by one
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            diff_skew <= `RST_DIFF_SKEW;
            edge_slip <= 1'b0;
            ratio_pin_ctl <= 1'b1;
            div_by_two <= 1'b0;
            drive_mode <= DRIVE_DIFF_FULL;
            num_format <= FORMAT_TWOS;
            loop_slow <= 1'b0;
            lc_hi_u0 <= `RST_ZERO;
            lc_lo_u0 <= `RST_ZERO;
            lc_hi_u1 <= `RST_ZERO;
            lc_lo_u1 <= `RST_ZERO;
        end else begin
            diff_skew <= skew_r;
            edge_slip <= slip_r;
            ratio_pin_ctl <= (ratio_r == `RATIO_PIN);
            // reserved ratio codes run undivided rather than stopping the converter clock
            unique case (ratio_r)
                `RATIO_PIN: div_by_two <= pin_s2_r;
                `RATIO_DIV2: div_by_two <= 1'b1;
                default: div_by_two <= 1'b0;
            endcase
            unique case (drv_r)
                `DRV_DIFF_LOW: drive_mode <= DRIVE_DIFF_LOW;
                `DRV_SINGLE: drive_mode <= DRIVE_SINGLE_ENDED;
                default: drive_mode <= DRIVE_DIFF_FULL;
            endcase
            unique case (fmt_r)
                `FMT_GRAY: num_format <= FORMAT_GRAY;
                `FMT_OFFSET: num_format <= FORMAT_OFFSET;
                default: num_format <= FORMAT_TWOS;
            endcase
            loop_slow <= range_r;
            lc_hi_u0 <= lc_r[0];
            lc_lo_u0 <= lc_r[1];
            lc_hi_u1 <= lc_r[2];
            lc_lo_u1 <= lc_r[3];
        end
    end

    // ==========================================================
    // read path: answer one cycle after the strobe
    // rd_data holds between reads so the host may collect it late
    logic [7:0] rd_nxt;
    always_comb begin
        rd_nxt = 8'h00;
        unique case (addr)
            `OFS_DIFF_SKEW: rd_nxt = skew_r;
            `OFS_EDGE_SLIP: rd_nxt = {7'h00, slip_r};
            `OFS_CLK_RATIO: rd_nxt = {5'h00, ratio_r};
            `OFS_DRV_FMT: rd_nxt = {drv_r, 2'h0, fmt_r};
            `OFS_LOOP_RANGE: rd_nxt = {1'b0, range_r, 6'h00};
            `OFS_LC_HI_U0: rd_nxt = lc_r[0];
            `OFS_LC_LO_U0: rd_nxt = lc_r[1];
            // status bytes are read live from the core; writes have nowhere to land
            `OFS_LS_HI_U0: rd_nxt = ls_hi_u0_in;
            `OFS_LS_LO_U0: rd_nxt = ls_lo_u0_in;
            `OFS_LC_HI_U1: rd_nxt = lc_r[2];
            `OFS_LC_LO_U1: rd_nxt = lc_r[3];
            `OFS_LS_HI_U1: rd_nxt = ls_hi_u1_in;
            `OFS_LS_LO_U1: rd_nxt = ls_lo_u1_in;
            `OFS_CAL_STATE: rd_nxt = {7'h00, cal_done_in};
            default: rd_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_data <= 8'h00;
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= rd_en;
            if (rd_en) begin
                rd_data <= rd_nxt;
            end
        end
    end

    // ==========================================================
    // checks
    a_soft_keeps_cfg: assert property (@(posedge sys_clk) disable iff (!arst_n)
        soft_rst && !wr_en |=> $stable(ratio_r) && $stable(drv_r) && $stable(fmt_r) && $stable(range_r))
        else $error("soft reset changed a kept register");
    a_ratio_div2: assert property (@(posedge sys_clk) disable iff (!arst_n)
        ratio_r == `RATIO_DIV2 |=> div_by_two && !ratio_pin_ctl)
        else $error("divide by two not applied");
    a_ratio_div1: assert property (@(posedge sys_clk) disable iff (!arst_n)
        ratio_r == `RATIO_DIV1 |=> !div_by_two && !ratio_pin_ctl)
        else $error("divide by one not applied");
    a_drive_single: assert property (@(posedge sys_clk) disable iff (!arst_n)
        wr_en && addr == `OFS_DRV_FMT && wr_data[7:5] == `DRV_SINGLE |=> ##1 drive_mode == DRIVE_SINGLE_ENDED)
        else $error("single-ended drive not selected");
    a_format_gray: assert property (@(posedge sys_clk) disable iff (!arst_n)
        wr_en && addr == `OFS_DRV_FMT && wr_data[2:0] == `FMT_GRAY |=> ##1 num_format == FORMAT_GRAY)
        else $error("gray format not selected");
    a_range_write: assert property (@(posedge sys_clk) disable iff (!arst_n)
        wr_en && addr == `OFS_LOOP_RANGE |=> ##1 loop_slow == $past(wr_data[6], 2))
        else $error("loop range mismatch");
    a_cal_read: assert property (@(posedge sys_clk) disable iff (!arst_n)
        rd_en && addr == `OFS_CAL_STATE |=> rd_valid && rd_data == {7'h00, $past(cal_done_in)})
        else $error("calibration status read wrong");
    a_slip_soft: assert property (@(posedge sys_clk) disable iff (!arst_n)
        soft_rst |=> ##1 !edge_slip)
        else $error("slip not cleared by soft reset");
    a_reserved_zero: assert property (@(posedge sys_clk) disable iff (!arst_n)
        rd_en && (addr == 8'h75 || addr == 8'hb7) |=> rd_data == 8'h00)
        else $error("reserved address read nonzero");

    // ==========================================================
    // checks: clock ratio and power-up state
    a_ratio_pin: assert property (@(posedge sys_clk) disable iff (!arst_n)
        ratio_r == `RATIO_PIN |=> ratio_pin_ctl && div_by_two == $past(pin_s2_r))
        else $error("pin control not followed");
    a_ratio_reserved: assert property (@(posedge sys_clk) disable iff (!arst_n)
        ratio_r > `RATIO_DIV2 |=> !div_by_two && !ratio_pin_ctl)
        else $error("reserved ratio code not at divide by one");
    // no disable here: these two watch the reset level itself
    a_power_clear: assert property (@(posedge sys_clk)
        !arst_n |=> ratio_r == 3'h0 && drv_r == 3'h0 && fmt_r == 3'h0 && !range_r)
        else $error("kept register not cleared at power-up");
    a_power_outputs: assert property (@(posedge sys_clk)
        !arst_n |=> ratio_pin_ctl && !div_by_two && drive_mode == DRIVE_DIFF_FULL && num_format == FORMAT_TWOS
            && !loop_slow)
        else $error("decoded outputs not at power-up defaults");

    // ==========================================================
    // checks: output driver and number format
    a_drive_low: assert property (@(posedge sys_clk) disable iff (!arst_n)
        wr_en && addr == `OFS_DRV_FMT && wr_data[7:5] == `DRV_DIFF_LOW |=> ##1 drive_mode == DRIVE_DIFF_LOW)
        else $error("reduced differential drive not selected");
    a_drive_default: assert property (@(posedge sys_clk) disable iff (!arst_n)
        wr_en && addr == `OFS_DRV_FMT && wr_data[7:5] != `DRV_DIFF_LOW && wr_data[7:5] != `DRV_SINGLE
            |=> ##1 drive_mode == DRIVE_DIFF_FULL)
        else $error("default or reserved drive code not at full differential");
    a_format_offset: assert property (@(posedge sys_clk) disable iff (!arst_n)
        wr_en && addr == `OFS_DRV_FMT && wr_data[2:0] == `FMT_OFFSET |=> ##1 num_format == FORMAT_OFFSET)
        else $error("offset binary format not selected");
    a_format_default: assert property (@(posedge sys_clk) disable iff (!arst_n)
        wr_en && addr == `OFS_DRV_FMT && wr_data[2:0] != `FMT_GRAY && wr_data[2:0] != `FMT_OFFSET
            |=> ##1 num_format == FORMAT_TWOS)
        else $error("default or reserved format code not at twos complement");

    // ==========================================================
    // checks: edge slip, read-only and reserved locations
    a_slip_write: assert property (@(posedge sys_clk) disable iff (!arst_n)
        wr_en && !soft_rst && addr == `OFS_EDGE_SLIP |=> ##1 edge_slip == $past(wr_data[`SLIP_BIT], 2))
        else $error("edge slip request not applied");
    a_cal_ignored: assert property (@(posedge sys_clk) disable iff (!arst_n)
        wr_en && !soft_rst && addr == `OFS_CAL_STATE
            |=> $stable({skew_r, slip_r, ratio_r, drv_r, fmt_r, range_r, lc_r[0], lc_r[1], lc_r[2], lc_r[3]}))
        else $error("write to calibration status changed a register");
    a_reserved_write: assert property (@(posedge sys_clk) disable iff (!arst_n)
        wr_en && !soft_rst && (addr == 8'h75 || addr == 8'hb7 || addr == 8'h90)
            |=> $stable({skew_r, slip_r, ratio_r, drv_r, fmt_r, range_r, lc_r[0], lc_r[1], lc_r[2], lc_r[3]}))
        else $error("write to reserved address changed a register");
    a_slip_bits: assert property (@(posedge sys_clk) disable iff (!arst_n)
        rd_en && addr == `OFS_EDGE_SLIP |=> rd_data[7:1] == 7'h00)
        else $error("slip register reserved bits read nonzero");
    a_ratio_bits: assert property (@(posedge sys_clk) disable iff (!arst_n)
        rd_en && addr == `OFS_CLK_RATIO |=> rd_data[7:3] == 5'h00)
        else $error("ratio register reserved bits read nonzero");
    a_mode_bits: assert property (@(posedge sys_clk) disable iff (!arst_n)
        rd_en && addr == `OFS_DRV_FMT |=> rd_data[4:3] == 2'h0)
        else $error("driver format register reserved bits read nonzero");
    a_range_bits: assert property (@(posedge sys_clk) disable iff (!arst_n)
        rd_en && addr == `OFS_LOOP_RANGE |=> !rd_data[7] && rd_data[5:0] == 6'h00)
        else $error("loop range register reserved bits read nonzero");

endmodule : adc_config_output_register_bank

// File: verification/spi_host_model.sv
// host model issuing byte register accesses on the strobe interface
module spi_host_model (
    input wire logic sys_clk, // bench clock
    input wire logic rd_valid, // read answer pulse
    input wire logic [7:0] rd_data, // read byte
    output logic wr_en, // write strobe
    output logic rd_en, // read strobe
    output logic [7:0] addr, // register address
    output logic [7:0] wr_data // write byte
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = 8'h00;
        wr_data = 8'h00;
    end
    // ==========================================================
    // accesses; released lines flip so stale values never look valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        addr = a;
        wr_data = d;
        wr_en = 1'b1;
        @(negedge sys_clk);
        wr_en = 1'b0;
        addr = ~a;
        wr_data = ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(negedge sys_clk);
        addr = a;
        rd_en = 1'b1;
        @(negedge sys_clk);
        rd_en = 1'b0;
        addr = ~a;
        v = rd_valid;
        d = rd_data;
    endtask : rd
endmodule : spi_host_model

// File: verification/adc_config_output_register_bank_tb_top.sv
// self-checking bench for the configuration register bank
module adc_config_output_register_bank_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk, arst_n, soft_rst, wr_en, rd_en, cal_done_in, ratio_pin, rd_valid, edge_slip;
    logic ratio_pin_ctl, div_by_two, loop_slow;
    logic [7:0] addr, wr_data, rd_data, diff_skew, lc_hi_u0, lc_lo_u0, lc_hi_u1, lc_lo_u1, d, r;
    logic [7:0] ls_hi_u0_in, ls_lo_u0_in, ls_hi_u1_in, ls_lo_u1_in;
    logic [1:0] drive_mode, num_format;
    logic [2:0] c;
    int n_errors, n_compared, cyc;
    adc_config_output_register_bank dut_u (.sys_clk(sys_clk), .arst_n(arst_n), .soft_rst(soft_rst),
        .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wr_data(wr_data), .cal_done_in(cal_done_in),
        .ls_hi_u0_in(ls_hi_u0_in), .ls_lo_u0_in(ls_lo_u0_in), .ls_hi_u1_in(ls_hi_u1_in),
        .ls_lo_u1_in(ls_lo_u1_in), .ratio_pin(ratio_pin), .rd_data(rd_data), .rd_valid(rd_valid),
        .diff_skew(diff_skew), .edge_slip(edge_slip), .ratio_pin_ctl(ratio_pin_ctl), .div_by_two(div_by_two),
        .drive_mode(drive_mode), .num_format(num_format), .loop_slow(loop_slow), .lc_hi_u0(lc_hi_u0),
        .lc_lo_u0(lc_lo_u0), .lc_hi_u1(lc_hi_u1), .lc_lo_u1(lc_lo_u1));
    spi_host_model host_u (.sys_clk(sys_clk), .rd_valid(rd_valid), .rd_data(rd_data), .wr_en(wr_en),
        .rd_en(rd_en), .addr(addr), .wr_data(wr_data));
    // ==========================================================
    // clock, timeout, checking
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_errors++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] q;
        logic v;
        host_u.rd(a, q, v);
        chk("rd_valid", {7'h0, v}, 8'h01);
        chk("rd_data", q, exp);
    endtask : rchk
    // reserved codes decode as the default
    function automatic logic [7:0] drv_exp(input logic [2:0] k);
        return (k == 3'h1) ? 8'h01 : (k == 3'h4) ? 8'h02 : 8'h00;
    endfunction : drv_exp
    function automatic logic [7:0] fmt_exp(input logic [2:0] k);
        return (k == 3'h2) ? 8'h01 : (k == 3'h4) ? 8'h02 : 8'h00;
    endfunction : fmt_exp
    // ==========================================================
    // main sequence
    initial begin
        n_errors = 0;
        n_compared = 0;
        cyc = 0;
        arst_n = 1'b0;
        soft_rst = 1'b0;
        cal_done_in = 1'b1;
        ratio_pin = 1'b0;
        void'($urandom(32'hc664));
        ls_hi_u0_in = 8'($urandom);
        ls_lo_u0_in = 8'($urandom);
        ls_hi_u1_in = 8'($urandom);
        ls_lo_u1_in = 8'($urandom);
        repeat (4) @(negedge sys_clk);
        arst_n = 1'b1;
        chk("ratio_pin_ctl", {7'h0, ratio_pin_ctl}, 8'h01);
        chk("diff_skew", diff_skew, 8'h80);
        for (int i = 0; i < 5; i++) begin
            rchk(8'h70 + 8'(i), (i == 0) ? 8'h80 : 8'h00);
        end
        host_u.wr(8'hb6, 8'h00);
        host_u.wr(8'ha6, ~ls_hi_u0_in);
        rchk(8'hb6, 8'h01);
        rchk(8'ha6, ls_hi_u0_in);
        rchk(8'ha7, ls_lo_u0_in);
        rchk(8'haa, ls_hi_u1_in);
        rchk(8'hab, ls_lo_u1_in);
        cal_done_in = 1'b0;
        host_u.wr(8'hb6, 8'hff);
        rchk(8'hb6, 8'h00);
        host_u.wr(8'h75, 8'hff);
        host_u.wr(8'hb7, 8'hff);
        rchk(8'h75, 8'h00);
        rchk(8'hb7, 8'h00);
        for (int i = 0; i < 8; i++) begin
            c = 3'(i);
            ratio_pin = 1'($urandom);
            host_u.wr(8'h72, {5'($urandom), c});
            repeat (3) @(negedge sys_clk);
            chk("ratio_pin_ctl", {7'h0, ratio_pin_ctl}, {7'h0, c == 3'h0});
            chk("div_by_two", {7'h0, div_by_two}, {7'h0, c == 3'h2 || (c == 3'h0 && ratio_pin)});
            rchk(8'h72, {5'h0, c});
            d = {c, 2'($urandom), c};
            host_u.wr(8'h73, d);
            repeat (2) @(negedge sys_clk);
            chk("drive_mode", {6'h0, drive_mode}, drv_exp(c));
            chk("num_format", {6'h0, num_format}, fmt_exp(c));
            rchk(8'h73, d & 8'he7);
            d = c[0] ? 8'hff : 8'hbf;
            host_u.wr(8'h74, d);
            repeat (2) @(negedge sys_clk);
            chk("loop_slow", {7'h0, loop_slow}, {7'h0, c[0]});
            rchk(8'h74, d & 8'h40);
        end
        r = 8'($urandom);
        host_u.wr(8'h70, r);
        host_u.wr(8'h71, 8'hff);
        host_u.wr(8'h72, 8'h02);
        host_u.wr(8'h73, 8'h82);
        host_u.wr(8'h74, 8'h40);
        host_u.wr(8'ha4, r);
        host_u.wr(8'ha9, ~r);
        host_u.wr(8'ha5, r ^ 8'h5a);
        host_u.wr(8'ha8, r ^ 8'ha5);
        host_u.wr(8'h90, 8'hff);
        repeat (2) @(negedge sys_clk);
        chk("diff_skew", diff_skew, r);
        chk("edge_slip", {7'h0, edge_slip}, 8'h01);
        chk("lc_hi_u0", lc_hi_u0, r);
        chk("lc_lo_u1", lc_lo_u1, ~r);
        chk("lc_lo_u0", lc_lo_u0, r ^ 8'h5a);
        chk("lc_hi_u1", lc_hi_u1, r ^ 8'ha5);
        rchk(8'ha5, r ^ 8'h5a);
        rchk(8'ha8, r ^ 8'ha5);
        rchk(8'ha9, ~r);
        rchk(8'h71, 8'h01);
        rchk(8'h90, 8'h00);
        soft_rst = 1'b1;
        @(negedge sys_clk);
        soft_rst = 1'b0;
        repeat (2) @(negedge sys_clk);
        chk("edge_slip", {7'h0, edge_slip}, 8'h00);
        chk("div_by_two", {7'h0, div_by_two}, 8'h01);
        chk("drive_mode", {6'h0, drive_mode}, 8'h02);
        rchk(8'h70, 8'h80);
        rchk(8'h72, 8'h02);
        rchk(8'h73, 8'h82);
        rchk(8'h74, 8'h40);
        rchk(8'ha4, r);
        arst_n = 1'b0;
        @(negedge sys_clk);
        arst_n = 1'b1;
        chk("drive_mode", {6'h0, drive_mode}, 8'h00);
        chk("div_by_two", {7'h0, div_by_two}, 8'h00);
        rchk(8'h72, 8'h00);
        rchk(8'h73, 8'h00);
        rchk(8'h74, 8'h00);
        end_of_test();
    end
endmodule : adc_config_output_register_bank_tb_top
